// *** hdl/crag_defines.svh ***
// Constants of the processor-core state and address-generation block.
// Assumes inclusion by bare name from the package and the core module.
`ifndef CRAG_DEFINES_SVH
`define CRAG_DEFINES_SVH

`define CRAG_PC_RESET     32'h0FFF_FFF0
`define CRAG_PC_STEP16    32'h0000_0002
`define CRAG_PC_STEP32    32'h0000_0004
`define CRAG_GPR_ZERO     5'h00
`define CRAG_GPR_AUX      5'h1E
`define CRAG_GPR_LINK     5'h1F
`define CRAG_SYSREG_COUNT 4'hB
`define CRAG_MEM_BYTES    4096
`define CRAG_MEM_WORDS    1024
`define CRAG_MEM_IDX_LSB  2
`define CRAG_MEM_IDX_MSB  11
`define CRAG_DISP9_SIGN   8
`define CRAG_DISP26_SIGN  25
`define CRAG_BYTE_SIGN    7
`define CRAG_HALF_SIGN    15
`define CRAG_WORD_SIGN    31

`endif

// *** hdl/crag_pkg.sv ***
// Types of the processor-core state and address-generation block.
// Assumes crag_defines.svh is on the include path.
`include "crag_defines.svh"
package crag_pkg;

  // Access sizes
  typedef enum logic [1:0] {
    CRAG_SIZE_BYTE = 2'b00,
    CRAG_SIZE_HALF = 2'b01,
    CRAG_SIZE_WORD = 2'b10
  } crag_size_e;

  // Kind of control transfer retiring with an instruction
  typedef enum logic [1:0] {
    CRAG_BR_NONE  = 2'b00,
    CRAG_BR_REL9  = 2'b01,
    CRAG_BR_REL26 = 2'b10,
    CRAG_BR_REG   = 2'b11
  } crag_branch_e;

  // Power state
  typedef enum logic {
    CRAG_PWR_RUN  = 1'b0,
    CRAG_PWR_STOP = 1'b1
  } crag_pwr_e;

  // Internal memory blocks
  typedef enum logic [1:0] {
    CRAG_BLK_ICACHE = 2'b00,
    CRAG_BLK_DCACHE = 2'b01,
    CRAG_BLK_IRAM   = 2'b10,
    CRAG_BLK_DRAM   = 2'b11
  } crag_block_e;

  typedef logic [31:0] crag_word_t;

endpackage

// *** hdl/crag_core.sv ***
// Core register state, program counter, address generation, stop mode
// and the four internal memories. Assumes a decoder outside that presents
// one retiring instruction per INSTR_DONE_I pulse, already decoded.
`timescale 1ns/1ns
`include "crag_defines.svh"
module crag_core (
  // Clock and reset
  input  wire logic                 CORE_CLK_I,
  input  wire logic                 SRST_I,
  // Register operand reads
  input  wire logic [4:0]           RD_A_SEL_I,
  input  wire logic [4:0]           RD_B_SEL_I,
  output logic      [31:0]          RD_A_DATA_O,
  output logic      [31:0]          RD_B_DATA_O,
  // Register writes
  input  wire logic                 WR_EN_I,
  input  wire logic [4:0]           WR_SEL_I,
  input  wire logic [31:0]          WR_DATA_I,
  input  wire logic                 MULDIV_EN_I,
  input  wire logic [31:0]          MULDIV_AUX_I,
  // System register access
  input  wire logic                 SYS_LOAD_I,
  input  wire logic                 SYS_STORE_I,
  input  wire logic [3:0]           SYS_SEL_I,
  input  wire logic [4:0]           SYS_GPR_I,
  output logic      [31:0]          SYS_DATA_O,
  // Instruction retire and branching
  input  wire logic                 INSTR_DONE_I,
  input  wire logic                 INSTR_LEN32_I,
  input  wire crag_pkg::crag_branch_e BRANCH_KIND_I,
  input  wire logic [25:0]          BRANCH_DISP_I,
  input  wire logic [4:0]           BRANCH_REG_I,
  input  wire logic                 JAL_I,
  input  wire logic                 STANDBY_I,
  output logic      [31:0]          PC_O,
  // Pins and power state
  input  wire logic                 NMI_N_I,
  input  wire logic                 HOLD_REQ_I,
  output logic                      HOLD_ACK_O,
  output logic                      PLL_RUN_O,
  output logic                      STOP_MODE_O,
  // Data access
  input  wire logic                 MEM_REQ_I,
  input  wire logic                 MEM_WE_I,
  input  wire logic                 MEM_INSTR_I,
  input  wire logic                 MEM_IO_I,
  input  wire logic                 MEM_SIGNED_I,
  input  wire crag_pkg::crag_size_e MEM_SIZE_I,
  input  wire crag_pkg::crag_block_e MEM_BLOCK_I,
  input  wire logic [31:0]          MEM_ADDR_I,
  input  wire logic [31:0]          MEM_WDATA_I,
  output logic      [31:0]          MEM_ADDR_O,
  output logic                      MEM_IO_O,
  output logic      [31:0]          MEM_RDATA_O,
  output logic                      MEM_REFUSED_O
);
  import crag_pkg::*;

  typedef struct packed {
    logic [31:0][31:0] gpr;
    logic [10:0][31:0] sys;
    logic [31:0]       pc;
    crag_pwr_e         pwr;
    logic [31:0]       rd_a;
    logic [31:0]       rd_b;
    logic [31:0]       sys_data;
    logic              nmi_meta;
    logic              nmi_sync;
    logic              nmi_prev;
    logic              hold_meta;
    logic              hold_sync;
    logic              hold_ack;
    logic              pll_run;
    logic [31:0]       addr;
    logic              io;
    logic [31:0]       rdata;
    logic              refused;
  } crag_state_s;

  crag_state_s st_reg;
  crag_state_s st_next;

  // Four blocks of 4K bytes; held outside the struct, no reset needed
  logic [31:0] mem_array [0:3][0:`CRAG_MEM_WORDS-1];

  logic [31:0] acc_addr;
  logic [9:0]  acc_idx;
  logic [3:0]  acc_be;
  logic [31:0] acc_lanes;
  logic        acc_ok;
  logic        acc_write;
  logic        nmi_fall;
  logic        run_step;

  // Sign extension above bit sb
  function automatic logic [31:0] sign_ext(input logic [31:0] v, input int unsigned sb);
    logic [31:0] r;
    r = v;
    for (int i = 0; i < 32; i++) begin
      if (i > sb) begin
        r[i] = v[sb];
      end
    end
    return r;
  endfunction

  // Register read with the zero register forced
  function automatic logic [31:0] gpr_read(input logic [31:0][31:0] g, input logic [4:0] s);
    if (s == `CRAG_GPR_ZERO) begin
      return 32'h0000_0000;
    end
    return g[s];
  endfunction

  // Silent alignment of a misaligned address
  function automatic logic [31:0] align_addr(input logic [31:0] a, input crag_size_e sz);
    logic [31:0] r;
    r = a;
    if (sz == CRAG_SIZE_HALF) begin
      r[0] = 1'b0;
    end else if (sz == CRAG_SIZE_WORD) begin
      r[1:0] = 2'b00;
    end
    return r;
  endfunction

  // Little-endian byte lanes: offset 0 is bits 7:0
  function automatic logic [3:0] lane_mask(input logic [1:0] a, input crag_size_e sz);
    if (sz == CRAG_SIZE_BYTE) begin
      return 4'h1 << a;
    end else if (sz == CRAG_SIZE_HALF) begin
      return a[1] ? 4'hC : 4'h3;
    end
    return 4'hF;
  endfunction

  // Address path shared by the memory write and the read path
  assign acc_addr  = align_addr(MEM_ADDR_I, MEM_SIZE_I);
  assign acc_idx   = acc_addr[`CRAG_MEM_IDX_MSB:`CRAG_MEM_IDX_LSB];
  assign acc_be    = lane_mask(acc_addr[1:0], MEM_SIZE_I);
  assign acc_lanes = (MEM_SIZE_I == CRAG_SIZE_BYTE) ? {4{MEM_WDATA_I[7:0]}} :
                     (MEM_SIZE_I == CRAG_SIZE_HALF) ? {2{MEM_WDATA_I[15:0]}} : MEM_WDATA_I;
  // Instruction fills only into instruction blocks, data only into data blocks
  assign acc_ok    = MEM_INSTR_I ? (MEM_BLOCK_I == CRAG_BLK_ICACHE ||
                                    MEM_BLOCK_I == CRAG_BLK_IRAM) :
                                   (MEM_BLOCK_I == CRAG_BLK_DCACHE ||
                                    MEM_BLOCK_I == CRAG_BLK_DRAM);
  // Stop freezes the memories too, so their contents survive to the wake
  assign acc_write = MEM_REQ_I && MEM_WE_I && !MEM_IO_I && acc_ok &&
                     st_reg.pwr == CRAG_PWR_RUN;
  // Synced falling edge; a pin held low cannot wake the core a second time
  assign nmi_fall  = st_reg.nmi_prev && !st_reg.nmi_sync;
  // Retires are ignored in stop, so the decoder need not gate them
  assign run_step  = INSTR_DONE_I && st_reg.pwr == CRAG_PWR_RUN;

  // Next state of everything but the memories
  always_comb begin
    logic [31:0] target;
    logic [31:0] word;
    logic [31:0] shifted;
    target  = 32'h0000_0000;
    word    = 32'h0000_0000;
    shifted = 32'h0000_0000;
    st_next = st_reg;
    st_next.refused = 1'b0;

    // Pin synchronisers; first stage feeds the second only
    st_next.nmi_meta  = NMI_N_I;
    st_next.nmi_sync  = st_reg.nmi_meta;
    st_next.nmi_prev  = st_reg.nmi_sync;
    st_next.hold_meta = HOLD_REQ_I;
    st_next.hold_sync = st_reg.hold_meta;

    // Operand reads
    st_next.rd_a = gpr_read(st_reg.gpr, RD_A_SEL_I);
    st_next.rd_b = gpr_read(st_reg.gpr, RD_B_SEL_I);

    // Program counter and power state
    if (run_step) begin
      if (BRANCH_KIND_I == CRAG_BR_REL9) begin
        target = st_reg.pc + sign_ext({23'h0, BRANCH_DISP_I[8:0]}, `CRAG_DISP9_SIGN);
      end else if (BRANCH_KIND_I == CRAG_BR_REL26) begin
        target = st_reg.pc + sign_ext({6'h00, BRANCH_DISP_I}, `CRAG_DISP26_SIGN);
      end else if (BRANCH_KIND_I == CRAG_BR_REG) begin
        target = gpr_read(st_reg.gpr, BRANCH_REG_I);
      end else begin
        target = st_reg.pc + (INSTR_LEN32_I ? `CRAG_PC_STEP32 : `CRAG_PC_STEP16);
      end
      st_next.pc = {target[31:1], 1'b0};
      if (STANDBY_I) begin
        st_next.pwr = CRAG_PWR_STOP;
      end
    end
    // Only the nonmaskable request wakes the core; there is no maskable input
    if (st_reg.pwr == CRAG_PWR_STOP && nmi_fall) begin
      st_next.pwr = CRAG_PWR_RUN;
    end

    // Register writes; implicit ones take priority over the general port
    if (st_reg.pwr == CRAG_PWR_RUN) begin
      if (WR_EN_I) begin
        st_next.gpr[WR_SEL_I] = WR_DATA_I;
      end
      if (SYS_STORE_I && SYS_SEL_I < `CRAG_SYSREG_COUNT) begin
        st_next.gpr[SYS_GPR_I] = st_reg.sys[SYS_SEL_I];
      end
      if (SYS_LOAD_I && SYS_SEL_I < `CRAG_SYSREG_COUNT) begin
        st_next.sys[SYS_SEL_I] = gpr_read(st_reg.gpr, SYS_GPR_I);
      end
      if (MULDIV_EN_I) begin
        st_next.gpr[`CRAG_GPR_AUX] = MULDIV_AUX_I;
      end
      if (run_step && JAL_I) begin
        st_next.gpr[`CRAG_GPR_LINK] = st_reg.pc + `CRAG_PC_STEP32;
      end
    end
    st_next.gpr[`CRAG_GPR_ZERO] = 32'h0000_0000;
    st_next.sys_data = (SYS_SEL_I < `CRAG_SYSREG_COUNT) ? st_reg.sys[SYS_SEL_I] : 32'h0000_0000;

    // Data access: aligned address and extended read value
    if (MEM_REQ_I && st_reg.pwr == CRAG_PWR_RUN) begin
      st_next.addr = acc_addr;
      st_next.io   = MEM_IO_I;
      st_next.refused = MEM_WE_I && !MEM_IO_I && !acc_ok;
      if (!MEM_WE_I && !MEM_IO_I) begin
        word    = mem_array[MEM_BLOCK_I][acc_idx];
        shifted = word >> {acc_addr[1:0], 3'b000};
        if (MEM_SIZE_I == CRAG_SIZE_BYTE) begin
          shifted = MEM_SIGNED_I ? sign_ext(shifted, `CRAG_BYTE_SIGN) :
                                   {24'h00_0000, shifted[7:0]};
        end else if (MEM_SIZE_I == CRAG_SIZE_HALF) begin
          shifted = MEM_SIGNED_I ? sign_ext(shifted, `CRAG_HALF_SIGN) :
                                   {16'h0000, shifted[15:0]};
        end
        st_next.rdata = shifted;
      end
    end

    // Stop halts the loop and blocks bus hold
    st_next.pll_run  = (st_next.pwr == CRAG_PWR_RUN);
    st_next.hold_ack = st_reg.hold_sync && st_next.pwr == CRAG_PWR_RUN;
  end

  // State register
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      st_reg          <= '0;
      st_reg.pc       <= `CRAG_PC_RESET;
      st_reg.nmi_meta <= 1'b1;
      st_reg.nmi_sync <= 1'b1;
      st_reg.nmi_prev <= 1'b1;
      st_reg.pll_run  <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Byte-lane memory writes, one cycle, refused blocks untouched
  always_ff @(posedge CORE_CLK_I) begin
    if (acc_write) begin
      for (int b = 0; b < 4; b++) begin
        if (acc_be[b]) begin
          mem_array[MEM_BLOCK_I][acc_idx][b*8 +: 8] <= acc_lanes[b*8 +: 8];
        end
      end
    end
  end

  // Outputs straight from the state register
  assign RD_A_DATA_O   = st_reg.rd_a;
  assign RD_B_DATA_O   = st_reg.rd_b;
  assign SYS_DATA_O    = st_reg.sys_data;
  assign PC_O          = st_reg.pc;
  assign HOLD_ACK_O    = st_reg.hold_ack;
  assign PLL_RUN_O     = st_reg.pll_run;
  assign STOP_MODE_O   = (st_reg.pwr == CRAG_PWR_STOP);
  assign MEM_ADDR_O    = st_reg.addr;
  assign MEM_IO_O      = st_reg.io;
  assign MEM_RDATA_O   = st_reg.rdata;
  assign MEM_REFUSED_O = st_reg.refused;

  // All checks run on the core clock and rest while reset is high
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SRST_I);

  sequence s_plain_step16;
    INSTR_DONE_I && !STOP_MODE_O && BRANCH_KIND_I == CRAG_BR_NONE && !INSTR_LEN32_I;
  endsequence
  sequence s_standby;
    INSTR_DONE_I && STANDBY_I && !STOP_MODE_O;
  endsequence

  // Register reads and program counter
  a_zero_reads: assert property ($past(RD_A_SEL_I) == 5'h00 && !$past(SRST_I) |->
    RD_A_DATA_O == 32'h0000_0000) else $error("zero register read nonzero");
  a_pc_even: assert property (PC_O[0] == 1'b0)
    else $error("pc bit 0 set");
  a_pc_step: assert property (s_plain_step16 |=> PC_O == $past(PC_O) + 32'h0000_0002)
    else $error("pc did not advance by 2");
  a_rel_branch: assert property (INSTR_DONE_I && !STOP_MODE_O &&
    BRANCH_KIND_I == CRAG_BR_REL9 |=> PC_O == (($past(PC_O) +
    sign_ext({23'h0, $past(BRANCH_DISP_I[8:0])}, 8)) & 32'hFFFF_FFFE))
    else $error("relative branch target wrong");
  // Stop mode entry, exit and side effects
  a_stop_entry: assert property (s_standby |=> STOP_MODE_O && !PLL_RUN_O)
    else $error("standby did not stop the core");
  a_stop_stays: assert property (STOP_MODE_O && !nmi_fall |=> STOP_MODE_O)
    else $error("stop mode left without nmi");
  a_stop_wakes: assert property (STOP_MODE_O && nmi_fall |=> !STOP_MODE_O ##1 PLL_RUN_O)
    else $error("nmi did not wake the core");
  a_pll_halt: assert property (STOP_MODE_O |-> !PLL_RUN_O)
    else $error("loop running in stop mode");
  a_hold_block: assert property (STOP_MODE_O |-> !HOLD_ACK_O)
    else $error("hold granted in stop mode");
  // Memory path, implicit register writes and the reset value of the program counter
  a_instr_guard: assert property (MEM_REQ_I && MEM_WE_I && !MEM_INSTR_I && !MEM_IO_I &&
    !STOP_MODE_O && MEM_BLOCK_I == CRAG_BLK_IRAM |=> MEM_REFUSED_O)
    else $error("data write into instruction ram not refused");
  a_word_align: assert property (MEM_REQ_I && !STOP_MODE_O &&
    MEM_SIZE_I == CRAG_SIZE_WORD |=> MEM_ADDR_O[1:0] == 2'b00 &&
    MEM_ADDR_O[31:2] == $past(MEM_ADDR_I[31:2])) else $error("word address not aligned");
  a_link_write: assert property (INSTR_DONE_I && JAL_I && !STOP_MODE_O &&
    RD_A_SEL_I == 5'h1F ##1 RD_A_SEL_I == 5'h1F |=> RD_A_DATA_O == $past(PC_O, 2) + 32'h4)
    else $error("link register not written");
  a_pc_reset: assert property ($fell(SRST_I) |-> PC_O == `CRAG_PC_RESET)
    else $error("pc reset value wrong");

  // Frozen counter and data path checks
  sequence s_mem_read;
    MEM_REQ_I && !MEM_WE_I && !MEM_IO_I && !STOP_MODE_O;
  endsequence

  a_pc_frozen: assert property (STOP_MODE_O |=> $stable(PC_O))
    else $error("pc moved in stop mode");
  a_io_space: assert property (MEM_REQ_I && MEM_IO_I && !STOP_MODE_O |=>
    MEM_IO_O && !MEM_REFUSED_O) else $error("io access not flagged");
  a_half_align: assert property (MEM_REQ_I && !STOP_MODE_O &&
    MEM_SIZE_I == CRAG_SIZE_HALF |=> MEM_ADDR_O[0] == 1'b0 &&
    MEM_ADDR_O[31:1] == $past(MEM_ADDR_I[31:1])) else $error("half address not aligned");
  a_byte_extend: assert property (s_mem_read ##0 MEM_SIZE_I == CRAG_SIZE_BYTE |=>
    MEM_RDATA_O[31:8] == (($past(MEM_SIGNED_I) && MEM_RDATA_O[7]) ? 24'hFF_FFFF :
    24'h00_0000)) else $error("byte read extended wrongly");

endmodule // crag_core

// *** dv/crag_core_tb_top.sv ***
// Self-checking bench for the core register, program counter, memory and stop logic.
// Assumes crag_pkg and crag_core are compiled first, crag_defines.svh on the path.
`timescale 1ns/1ns
module crag_core_tb_top;
  import crag_pkg::*;

  // Stimulus, all driven from time zero
  logic         clk = 1'b0, srst = 1'b1, nmi_n = 1'b1, hold_req = 1'b0;
  logic [4:0]   rd_a_sel = '0, rd_b_sel = '0, wr_sel = '0, sys_gpr = '0, br_reg = '0;
  logic         wr_en = 1'b0, muldiv_en = 1'b0, sys_load = 1'b0, sys_store = 1'b0;
  logic [31:0]  wr_data = '0, muldiv_aux = '0, mem_addr = '0, mem_wdata = '0;
  logic [3:0]   sys_sel = '0;
  logic         instr_done = 1'b0, len32 = 1'b0, jump_and_link_instruction = 1'b0, standby = 1'b0;
  crag_branch_e br_kind = CRAG_BR_NONE;
  logic [25:0]  br_disp = '0;
  logic         mem_req = 1'b0, mem_we = 1'b0, mem_instr = 1'b0, mem_io = 1'b0;
  logic         mem_signed = 1'b0;
  crag_size_e   mem_size = CRAG_SIZE_BYTE;
  crag_block_e  mem_block = CRAG_BLK_ICACHE;
  // Observed outputs
  logic [31:0]  rd_a_data, rd_b_data, sys_data, pc, m_addr, m_rdata;
  logic         hold_ack, pll_run, stop_mode, m_io, m_ref;
  // Bookkeeping
  int           errors = 0, check_count = 0;
  logic [31:0]  exp_pc, link;

  always #5 clk = ~clk;

  crag_core crag_core_inst (
    .CORE_CLK_I(clk), .SRST_I(srst),
    .RD_A_SEL_I(rd_a_sel), .RD_B_SEL_I(rd_b_sel),
    .RD_A_DATA_O(rd_a_data), .RD_B_DATA_O(rd_b_data),
    .WR_EN_I(wr_en), .WR_SEL_I(wr_sel), .WR_DATA_I(wr_data),
    .MULDIV_EN_I(muldiv_en), .MULDIV_AUX_I(muldiv_aux),
    .SYS_LOAD_I(sys_load), .SYS_STORE_I(sys_store), .SYS_SEL_I(sys_sel),
    .SYS_GPR_I(sys_gpr), .SYS_DATA_O(sys_data),
    .INSTR_DONE_I(instr_done), .INSTR_LEN32_I(len32), .BRANCH_KIND_I(br_kind),
    .BRANCH_DISP_I(br_disp), .BRANCH_REG_I(br_reg), .JAL_I(jump_and_link_instruction), .STANDBY_I(standby),
    .PC_O(pc), .NMI_N_I(nmi_n), .HOLD_REQ_I(hold_req), .HOLD_ACK_O(hold_ack),
    .PLL_RUN_O(pll_run), .STOP_MODE_O(stop_mode),
    .MEM_REQ_I(mem_req), .MEM_WE_I(mem_we), .MEM_INSTR_I(mem_instr), .MEM_IO_I(mem_io),
    .MEM_SIGNED_I(mem_signed), .MEM_SIZE_I(mem_size), .MEM_BLOCK_I(mem_block),
    .MEM_ADDR_I(mem_addr), .MEM_WDATA_I(mem_wdata), .MEM_ADDR_O(m_addr),
    .MEM_IO_O(m_io), .MEM_RDATA_O(m_rdata), .MEM_REFUSED_O(m_ref)
  );

  // Verdict in one place, reached by the main sequence or the watchdog
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Comparisons; case equality so an unknown never matches
  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Distinct per-register pattern, bit 0 set for odd registers so jumps exercise masking
  function automatic logic [31:0] pat(input logic [4:0] i);
    return {4{3'b101, i}};
  endfunction

  // Bus-like helpers: launch after an edge, hold through the taking edge
  task automatic wr_gpr(input logic [4:0] s, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    wr_sel <= s;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rdchk(input logic [4:0] s, input logic [31:0] exp);
    @(posedge clk);
    rd_a_sel <= s;
    rd_b_sel <= s;
    @(posedge clk);
    #1;
    chk32("read port a", exp, rd_a_data);
    chk32("read port b", exp, rd_b_data);
  endtask
  task automatic retire(input logic l, input crag_branch_e k, input logic [25:0] d,
                        input logic [4:0] r, input logic j, input logic s);
    @(posedge clk);
    instr_done <= 1'b1;
    len32 <= l;
    br_kind <= k;
    br_disp <= d;
    br_reg <= r;
    jump_and_link_instruction <= j;
    standby <= s;
    @(posedge clk);
    instr_done <= 1'b0;
    jump_and_link_instruction <= 1'b0;
    standby <= 1'b0;
    #1;
  endtask
  task automatic mem(input logic we, input logic ins, input logic io, input logic sg,
                     input crag_size_e sz, input crag_block_e b, input logic [31:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    mem_req <= 1'b1;
    mem_we <= we;
    mem_instr <= ins;
    mem_io <= io;
    mem_signed <= sg;
    mem_size <= sz;
    mem_block <= b;
    mem_addr <= a;
    mem_wdata <= wd;
    @(posedge clk);
    mem_req <= 1'b0;
    #1;
  endtask

  // Register file: every register, the zero register and the aux register
  task automatic t_gpr;
    for (int i = 1; i < 32; i++) wr_gpr(i[4:0], pat(i[4:0]));
    wr_gpr(5'h00, 32'hFFFF_FFFF);
    for (int i = 0; i < 32; i++) rdchk(i[4:0], (i == 0) ? 32'h0 : pat(i[4:0]));
    rdchk(5'h00, 32'h0000_0000);
    @(posedge clk);
    muldiv_en <= 1'b1;
    muldiv_aux <= 32'h1357_9BDF;
    @(posedge clk);
    muldiv_en <= 1'b0;
    rdchk(5'h1E, 32'h1357_9BDF);
    $display("test gpr done");
  endtask

  // Program counter stepping and the three branch forms
  task automatic t_pc;
    exp_pc = 32'h0FFF_FFF0;
    retire(1'b0, CRAG_BR_NONE, 26'h0, 5'h0, 1'b0, 1'b0);
    exp_pc = exp_pc + 32'h2;
    chk32("pc step 2", exp_pc, pc);
    retire(1'b1, CRAG_BR_NONE, 26'h0, 5'h0, 1'b0, 1'b0);
    exp_pc = exp_pc + 32'h4;
    chk32("pc step 4", exp_pc, pc);
    retire(1'b0, CRAG_BR_REL9, 26'h3FF_FDF0, 5'h0, 1'b0, 1'b0);
    exp_pc = exp_pc - 32'h10;
    chk32("pc rel9", exp_pc, pc);
    retire(1'b1, CRAG_BR_REL26, 26'h000_0101, 5'h0, 1'b0, 1'b0);
    exp_pc = (exp_pc + 32'h101) & 32'hFFFF_FFFE;
    chk32("pc rel26 odd", exp_pc, pc);
    link = exp_pc + 32'h4;
    @(posedge clk);
    rd_a_sel <= 5'h1F;
    retire(1'b1, CRAG_BR_REL26, 26'h3FF_FF00, 5'h0, 1'b1, 1'b0);
    exp_pc = exp_pc - 32'h100;
    chk32("pc rel26 back", exp_pc, pc);
    rdchk(5'h1F, link);
    retire(1'b0, CRAG_BR_REG, 26'h0, 5'h07, 1'b0, 1'b0);
    exp_pc = pat(5'h07) & 32'hFFFF_FFFE;
    chk32("pc reg jump", exp_pc, pc);
    $display("test pc done");
  endtask

  // Internal memories: lanes, masking, extension, refusals, I/O space
  task automatic t_mem;
    mem(1'b1, 1'b0, 1'b0, 1'b0, CRAG_SIZE_WORD, CRAG_BLK_DRAM, 32'h100, 32'h8877_6655);
    chk1("dram data write refused", 1'b0, m_ref);
    mem(1'b0, 1'b0, 1'b0, 1'b0, CRAG_SIZE_WORD, CRAG_BLK_DRAM, 32'h103, 32'h0);
    chk32("word addr", 32'h100, m_addr);
    chk32("word data", 32'h8877_6655, m_rdata);
    chk1("memory space", 1'b0, m_io);
    for (int k = 0; k < 4; k++) begin
      mem(1'b0, 1'b0, 1'b0, 1'b0, CRAG_SIZE_BYTE, CRAG_BLK_DRAM, 32'h100 + k, 32'h0);
      chk32("byte addr", 32'h100 + k, m_addr);
      chk32("byte lane", {24'h0, 8'h55 + 8'h11 * k[7:0]}, m_rdata);
    end
    mem(1'b0, 1'b0, 1'b0, 1'b1, CRAG_SIZE_BYTE, CRAG_BLK_DRAM, 32'h103, 32'h0);
    chk32("signed byte", 32'hFFFF_FF88, m_rdata);
    mem(1'b0, 1'b0, 1'b0, 1'b1, CRAG_SIZE_HALF, CRAG_BLK_DRAM, 32'h103, 32'h0);
    chk32("half addr", 32'h102, m_addr);
    chk32("signed half", 32'hFFFF_8877, m_rdata);
    mem(1'b1, 1'b0, 1'b0, 1'b0, CRAG_SIZE_WORD, CRAG_BLK_DCACHE, 32'h300, 32'h0000_0000);
    mem(1'b1, 1'b0, 1'b0, 1'b0, CRAG_SIZE_BYTE, CRAG_BLK_DCACHE, 32'h301, 32'h0000_00A5);
    mem(1'b1, 1'b0, 1'b0, 1'b0, CRAG_SIZE_HALF, CRAG_BLK_DCACHE, 32'h303, 32'h0000_B4C3);
    mem(1'b0, 1'b0, 1'b0, 1'b0, CRAG_SIZE_WORD, CRAG_BLK_DCACHE, 32'h300, 32'h0);
    chk32("lane writes", 32'hB4C3_A500, m_rdata);
    mem(1'b0, 1'b0, 1'b0, 1'b0, CRAG_SIZE_HALF, CRAG_BLK_DCACHE, 32'h302, 32'h0);
    chk32("unsigned half", 32'h0000_B4C3, m_rdata);
    for (int b = 0; b < 4; b++) begin
      for (int n = 0; n < 2; n++) begin
        mem(1'b1, n[0], 1'b0, 1'b0, CRAG_SIZE_WORD, crag_block_e'(b[1:0]), 32'h200,
            n[0] ? 32'hBAD0_BAD0 : 32'h600D_600D);
        chk1("write refused", b[0] == n[0], m_ref);
      end
    end
    mem(1'b0, 1'b0, 1'b0, 1'b0, CRAG_SIZE_WORD, CRAG_BLK_DRAM, 32'h200, 32'h0);
    chk32("dram after instr write", 32'h600D_600D, m_rdata);
    mem(1'b0, 1'b0, 1'b0, 1'b0, CRAG_SIZE_WORD, CRAG_BLK_IRAM, 32'h200, 32'h0);
    chk32("iram after data write", 32'hBAD0_BAD0, m_rdata);
    mem(1'b0, 1'b0, 1'b1, 1'b0, CRAG_SIZE_WORD, CRAG_BLK_DRAM, 32'hFFFF_FFFE, 32'h0);
    chk32("io addr", 32'hFFFF_FFFC, m_addr);
    chk1("io space", 1'b1, m_io);
    $display("test mem done");
  endtask

  // System registers: load from and store back to the register file
  task automatic t_sys;
    wr_gpr(5'h09, 32'hC3C3_3C3C);
    @(posedge clk);
    sys_load <= 1'b1;
    sys_sel <= 4'hA;
    sys_gpr <= 5'h09;
    @(posedge clk);
    sys_load <= 1'b0;
    @(posedge clk);
    #1;
    chk32("sysreg 10", 32'hC3C3_3C3C, sys_data);
    @(posedge clk);
    sys_store <= 1'b1;
    sys_gpr <= 5'h0C;
    @(posedge clk);
    sys_store <= 1'b0;
    rdchk(5'h0C, 32'hC3C3_3C3C);
    $display("test sys done");
  endtask

  // Stop mode: entry, frozen state, hold refusal, exit by NMI and by reset
  task automatic t_stop;
    @(posedge clk);
    hold_req <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk1("hold granted in run", 1'b1, hold_ack);
    retire(1'b0, CRAG_BR_NONE, 26'h0, 5'h0, 1'b0, 1'b1);
    exp_pc = exp_pc + 32'h2;
    chk1("stop entered", 1'b1, stop_mode);
    chk1("loop halted", 1'b0, pll_run);
    chk1("hold refused", 1'b0, hold_ack);
    wr_gpr(5'h05, 32'h0000_0000);
    retire(1'b1, CRAG_BR_NONE, 26'h0, 5'h0, 1'b0, 1'b0);
    rdchk(5'h05, pat(5'h05));
    chk32("pc frozen", exp_pc, pc);
    chk1("still stopped", 1'b1, stop_mode);
    chk1("hold still refused", 1'b0, hold_ack);
    @(posedge clk);
    nmi_n <= 1'b0;
    repeat (8) begin
      @(posedge clk);
      #1;
      if (stop_mode === 1'b0) break;
    end
    chk1("nmi exit", 1'b0, stop_mode);
    chk1("loop running", 1'b1, pll_run);
    @(posedge clk);
    nmi_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk1("hold granted again", 1'b1, hold_ack);
    retire(1'b0, CRAG_BR_NONE, 26'h0, 5'h0, 1'b0, 1'b1);
    chk1("stop again", 1'b1, stop_mode);
    @(posedge clk);
    srst <= 1'b1;
    hold_req <= 1'b0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    chk1("reset exit", 1'b0, stop_mode);
    chk32("pc after reset", 32'h0FFF_FFF0, pc);
    $display("test stop done");
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    chk32("reset pc", 32'h0FFF_FFF0, pc);
    chk1("reset run", 1'b0, stop_mode);
    $display("test reset done");
    t_gpr;
    t_pc;
    t_mem;
    t_sys;
    t_stop;
    report_and_stop;
  end

  // Watchdog: tests need well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("[ERR] watchdog expected finish seen hang");
    report_and_stop;
  end
endmodule // crag_core_tb_top
